// File: asrw_consts.vh
// register map, field positions and reset values of the serial receiver
`ifndef ASRW_CONSTS_VH
`define ASRW_CONSTS_VH
// register byte addresses
`define ASRW_ADDR_RX_STATUS_CTRL   8'h00
`define ASRW_ADDR_RX_DATA_PORT     8'h04
`define ASRW_ADDR_TX_STATUS_CTRL   8'h08
`define ASRW_ADDR_BAUD_CTRL        8'h0C
`define ASRW_ADDR_BAUD_DIV_HIGH    8'h10
`define ASRW_ADDR_BAUD_DIV_LOW     8'h14
`define ASRW_ADDR_IRQ_CTRL         8'h18
// receive_status_control fields
`define ASRW_RSC_SERIAL_PORT_EN    7
`define ASRW_RSC_NINE_BIT_EN       6
`define ASRW_RSC_SINGLE_RX_EN      5
`define ASRW_RSC_CONT_RX_EN        4
`define ASRW_RSC_ADDR_DETECT_EN    3
`define ASRW_RSC_FRAMING_ERR       2
`define ASRW_RSC_OVERRUN_ERR       1
`define ASRW_RSC_NINTH_BIT         0
// transmit_status_control fields
`define ASRW_TSC_SYNC_MODE         4
`define ASRW_TSC_HIGH_SPEED        2
`define ASRW_TSC_SHIFTER_EMPTY     1
// baud_control fields
`define ASRW_BC_RX_IDLE            6
`define ASRW_BC_RX_POLARITY_INV    5
`define ASRW_BC_SIXTEEN_BIT_DIV    3
`define ASRW_BC_WAKEUP_EN          1
// interrupt control fields
`define ASRW_IRQ_ENABLE            0
`define ASRW_IRQ_FLAG              1
// reset values
`define ASRW_RST_RX_STATUS_CTRL    8'h00
`define ASRW_RST_TX_STATUS_CTRL    8'h02
`define ASRW_RST_BAUD_CTRL         8'h40
`define ASRW_RST_BAUD_DIV          8'h00
// timing counts in sample ticks, slow prescale count in generator ticks
`define ASRW_OVERSAMPLE            16
`define ASRW_START_MID             4'h7
`define ASRW_BIT_MID               4'hF
`define ASRW_SLOW_PRESCALE         2'h3
`endif

// File: asrw_top.v
// asynchronous serial receiver with wake-on-break behind an apb slave
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "asrw_consts.vh"

module asrw_top #(
	parameter FIFO_DEPTH = 2                   // characters held for software
) (
	input  wire        CLK_SYS,                // system clock, 50 MHz
	input  wire        RST,                    // synchronous reset, active high
	input  wire        PSEL,                   // apb select
	input  wire        PENABLE,                // apb access phase
	input  wire        PWRITE,                 // apb direction, high is write
	input  wire [7:0]  PADDR,                  // apb byte address
	input  wire [31:0] PWDATA,                 // apb write data
	output reg  [31:0] PRDATA,                 // apb read data, registered
	output wire        PREADY,                 // apb ready, never waits
	output wire        PSLVERR,                // apb error on unmapped address
	input  wire        SERIAL_INPUT_PIN,       // serial line from the remote sender
	input  wire        SLEEP_MODE,             // device asleep, module clocks stopped
	output wire        RECEIVE_IRQ             // receive interrupt request, level
);

	localparam ST_IDLE  = 3'h0;                // waiting for start edge
	localparam ST_START = 3'h1;                // checking start bit middle
	localparam ST_DATA  = 3'h2;                // shifting data bits
	localparam ST_STOP  = 3'h3;                // sampling stop bit
	localparam ST_WAKE  = 3'h4;                // suspended, watching for wake

	// control registers
	reg        serial_port_enable_q;           // port on
	reg        nine_bit_receive_enable_q;      // nine data bits
	reg        single_receive_enable_q;        // stored only, sync mode unused
	reg        continuous_receive_enable_q;    // receiver on
	reg        address_detect_enable_q;        // address filter on
	reg        sync_mode_q;                    // synchronous mode select
	reg        high_speed_baud_select_q;       // fast generator rate
	reg        receive_polarity_invert_q;      // invert line
	reg        sixteen_bit_divisor_select_q;   // use high divisor byte
	reg        wakeup_enable_q;                // wake watch active
	reg        receive_irq_enable_q;           // interrupt request gate
	reg  [7:0] baud_divisor_high_q;            // divisor upper byte
	reg  [7:0] baud_divisor_low_q;             // divisor lower byte
	// status
	reg        overrun_error_flag_q;           // fifo overrun, sticky
	reg        wake_flag_q;                    // wake event pending
	reg        wake_seen_q;                    // falling edge seen, await rise
	// receive path
	reg  [2:0] state_q;                        // receiver state
	reg  [3:0] sample_cnt_q;                   // ticks within a bit
	reg  [3:0] bit_cnt_q;                      // data bits taken
	reg  [8:0] receive_shifter_q;              // not visible to software
	reg        line_meta_q;                    // first sync stage
	reg        line_sync_q;                    // second sync stage
	reg        line_prev_q;                    // previous synced level
	// baud generator
	reg [15:0] brg_cnt_q;                      // down counter
	reg  [1:0] prescale_q;                     // slow-mode divide by four
	// fifo
	reg  [9:0] fifo_mem [0:FIFO_DEPTH-1];      // {framing, ninth, data}
	reg        wr_ptr_q;                       // write index
	reg        rd_ptr_q;                       // read index
	reg  [1:0] fifo_cnt_q;                     // characters held

	wire        rx_line;                       // polarity-corrected line
	wire        fall_edge;                     // line went high to low
	wire        rise_edge;                     // line went low to high
	wire        brg_tick;                      // generator output
	wire        sample_tick;                   // sixteen times bit rate
	wire        rx_enabled;                    // reception may run
	wire [15:0] divisor;                       // selected reload value
	wire        setup_ph;                      // apb setup cycle
	wire        access_ph;                     // apb completing cycle
	wire        wr_en;                         // write takes effect
	wire        rd_data_port;                  // data port read completes
	wire        addr_ok;                       // address is mapped
	wire        fifo_full;                     // no room left
	wire        fifo_empty;                    // nothing held
	wire        char_done;                     // stop bit sampled
	wire        char_keep;                     // passes address filter
	wire        push;                          // enter fifo
	wire        pop;                           // leave fifo
	wire        receive_irq_flag;              // character or wake pending
	wire [9:0]  head;                          // oldest entry

	// line synchroniser, only the second stage is looked at
	always @(posedge CLK_SYS) begin
		if (RST) begin
			line_meta_q <= 1'b1;
			line_sync_q <= 1'b1;
			line_prev_q <= 1'b1;
		end else begin
			line_meta_q <= SERIAL_INPUT_PIN;
			line_sync_q <= line_meta_q;
			line_prev_q <= rx_line;
		end
	end

	assign rx_line   = line_sync_q ^ receive_polarity_invert_q;
	assign fall_edge = line_prev_q & ~rx_line;
	assign rise_edge = ~line_prev_q & rx_line;

	// baud generator, frozen in sleep since its clock would be gone
	assign divisor = sixteen_bit_divisor_select_q ?
		{baud_divisor_high_q, baud_divisor_low_q} : {8'h00, baud_divisor_low_q};
	assign brg_tick = (brg_cnt_q == 16'h0000) & ~SLEEP_MODE;

	always @(posedge CLK_SYS) begin
		if (RST) begin
			brg_cnt_q  <= 16'h0000;
			prescale_q <= 2'h0;
		end else if (!SLEEP_MODE) begin
			if (brg_tick) begin
				brg_cnt_q <= divisor;
				prescale_q <= prescale_q + 2'h1;
			end else begin
				brg_cnt_q <= brg_cnt_q - 16'h0001;
			end
		end
	end

	// slow mode runs the generator at sixty-four times, others at sixteen
	assign sample_tick = brg_tick &
		((high_speed_baud_select_q | sixteen_bit_divisor_select_q) |
		 (prescale_q == `ASRW_SLOW_PRESCALE));

	assign rx_enabled = serial_port_enable_q & continuous_receive_enable_q &
		~sync_mode_q & ~overrun_error_flag_q & ~SLEEP_MODE;

	assign char_done = (state_q == ST_STOP) & sample_tick &
		(sample_cnt_q == `ASRW_BIT_MID);
	// filter drops data characters while address detect and nine-bit receive are both on
	assign char_keep = ~(nine_bit_receive_enable_q & address_detect_enable_q &
		~receive_shifter_q[8]);
	assign push = char_done & char_keep & ~fifo_full;

	// receive state machine
	always @(posedge CLK_SYS) begin
		if (RST) begin
			state_q           <= ST_IDLE;
			sample_cnt_q      <= 4'h0;
			bit_cnt_q         <= 4'h0;
			receive_shifter_q <= 9'h000;
		end else if (wakeup_enable_q) begin
			state_q      <= ST_WAKE;
			sample_cnt_q <= 4'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					sample_cnt_q <= 4'h0;
					if (rx_enabled && fall_edge) begin
						state_q <= ST_START;
					end
				end
				ST_START: begin
					if (!rx_enabled) begin
						state_q <= ST_IDLE;
					end else if (sample_tick) begin
						sample_cnt_q <= sample_cnt_q + 4'h1;
						if (sample_cnt_q == `ASRW_START_MID) begin
							sample_cnt_q <= 4'h0;
							bit_cnt_q    <= 4'h0;
							// a glitch that is high by mid-bit is no start
							state_q <= rx_line ? ST_IDLE : ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (!rx_enabled) begin
						state_q <= ST_IDLE;
					end else if (sample_tick) begin
						sample_cnt_q <= sample_cnt_q + 4'h1;
						if (sample_cnt_q == `ASRW_BIT_MID) begin
							// shift from the top so bit 0 ends lowest
							if (nine_bit_receive_enable_q) begin
								receive_shifter_q <= {rx_line, receive_shifter_q[8:1]};
							end else begin
								receive_shifter_q <= {1'b0, rx_line, receive_shifter_q[7:1]};
							end
							bit_cnt_q <= bit_cnt_q + 4'h1;
							if (bit_cnt_q == (nine_bit_receive_enable_q ? 4'h8 : 4'h7)) begin
								state_q <= ST_STOP;
							end
						end
					end
				end
				ST_STOP: begin
					if (!rx_enabled) begin
						state_q <= ST_IDLE;
					end else if (sample_tick) begin
						sample_cnt_q <= sample_cnt_q + 4'h1;
						if (sample_cnt_q == `ASRW_BIT_MID) begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_WAKE: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// two-entry fifo, framing and ninth bit travel with each character
	assign fifo_full  = (fifo_cnt_q == FIFO_DEPTH);
	assign fifo_empty = (fifo_cnt_q == 2'h0);
	assign head       = fifo_mem[rd_ptr_q];
	assign pop        = rd_data_port & ~fifo_empty;

	always @(posedge CLK_SYS) begin
		if (push) begin
			fifo_mem[wr_ptr_q] <= {~rx_line, receive_shifter_q};
		end
	end

	// fifo pointers and fill level
	always @(posedge CLK_SYS) begin
		if (RST) begin
			wr_ptr_q   <= 1'b0;
			rd_ptr_q   <= 1'b0;
			fifo_cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			if (push && !pop) begin
				fifo_cnt_q <= fifo_cnt_q + 2'h1;
			end else if (pop && !push) begin
				fifo_cnt_q <= fifo_cnt_q - 2'h1;
			end
		end
	end

	// overrun: set on a kept character with no room, cleared with receive enable
	always @(posedge CLK_SYS) begin
		if (RST) begin
			overrun_error_flag_q <= 1'b0;
		end else if (char_done && char_keep && fifo_full) begin
			overrun_error_flag_q <= 1'b1;
		end else if (!continuous_receive_enable_q) begin
			overrun_error_flag_q <= 1'b0;
		end
	end

	// wake watch; flag set wins over the clearing read
	always @(posedge CLK_SYS) begin
		if (RST) begin
			wake_flag_q <= 1'b0;
			wake_seen_q <= 1'b0;
		end else begin
			if (wakeup_enable_q && !wake_seen_q && fall_edge) begin
				wake_flag_q <= 1'b1;
				wake_seen_q <= 1'b1;
			end else if (rd_data_port) begin
				wake_flag_q <= 1'b0;
			end
			if (!wakeup_enable_q) begin
				wake_seen_q <= 1'b0;
			end
		end
	end

	assign receive_irq_flag = ~fifo_empty | wake_flag_q;
	assign RECEIVE_IRQ = receive_irq_flag & receive_irq_enable_q;

	// apb decode; zero wait states
	assign setup_ph  = PSEL & ~PENABLE;
	assign access_ph = PSEL & PENABLE;
	assign addr_ok   = (PADDR[1:0] == 2'h0) && (PADDR <= `ASRW_ADDR_IRQ_CTRL);
	assign wr_en     = access_ph & PWRITE & addr_ok;
	assign rd_data_port = access_ph & ~PWRITE & (PADDR == `ASRW_ADDR_RX_DATA_PORT);
	assign PREADY    = 1'b1;
	assign PSLVERR   = access_ph & ~addr_ok;

	// software-written control bits
	always @(posedge CLK_SYS) begin
		if (RST) begin
			serial_port_enable_q         <= 1'b0;
			nine_bit_receive_enable_q    <= 1'b0;
			single_receive_enable_q      <= 1'b0;
			continuous_receive_enable_q  <= 1'b0;
			address_detect_enable_q      <= 1'b0;
			sync_mode_q                  <= 1'b0;
			high_speed_baud_select_q     <= 1'b0;
			receive_polarity_invert_q    <= 1'b0;
			sixteen_bit_divisor_select_q <= 1'b0;
			wakeup_enable_q              <= 1'b0;
			receive_irq_enable_q         <= 1'b0;
			baud_divisor_high_q          <= `ASRW_RST_BAUD_DIV;
			baud_divisor_low_q           <= `ASRW_RST_BAUD_DIV;
		end else begin
			// hardware ends the wake watch on the rising edge after the event
			if (wakeup_enable_q && wake_seen_q && rise_edge) begin
				wakeup_enable_q <= 1'b0;
			end
			if (wr_en) begin
				case (PADDR)
					`ASRW_ADDR_RX_STATUS_CTRL: begin
						serial_port_enable_q        <= PWDATA[`ASRW_RSC_SERIAL_PORT_EN];
						nine_bit_receive_enable_q   <= PWDATA[`ASRW_RSC_NINE_BIT_EN];
						single_receive_enable_q     <= PWDATA[`ASRW_RSC_SINGLE_RX_EN];
						continuous_receive_enable_q <= PWDATA[`ASRW_RSC_CONT_RX_EN];
						address_detect_enable_q     <= PWDATA[`ASRW_RSC_ADDR_DETECT_EN];
					end
					`ASRW_ADDR_TX_STATUS_CTRL: begin
						sync_mode_q              <= PWDATA[`ASRW_TSC_SYNC_MODE];
						high_speed_baud_select_q <= PWDATA[`ASRW_TSC_HIGH_SPEED];
					end
					`ASRW_ADDR_BAUD_CTRL: begin
						receive_polarity_invert_q    <= PWDATA[`ASRW_BC_RX_POLARITY_INV];
						sixteen_bit_divisor_select_q <= PWDATA[`ASRW_BC_SIXTEEN_BIT_DIV];
						wakeup_enable_q              <= PWDATA[`ASRW_BC_WAKEUP_EN];
					end
					`ASRW_ADDR_BAUD_DIV_HIGH: baud_divisor_high_q <= PWDATA[7:0];
					`ASRW_ADDR_BAUD_DIV_LOW:  baud_divisor_low_q  <= PWDATA[7:0];
					`ASRW_ADDR_IRQ_CTRL: receive_irq_enable_q <= PWDATA[`ASRW_IRQ_ENABLE];
					default: begin
					end
				endcase
			end
		end
	end

	// read data captured in the setup cycle, stable through the access
	always @(posedge CLK_SYS) begin
		if (RST) begin
			PRDATA <= 32'h00000000;
		end else if (setup_ph) begin
			PRDATA <= 32'h00000000;
			case (PADDR)
				`ASRW_ADDR_RX_STATUS_CTRL: begin
					PRDATA[`ASRW_RSC_SERIAL_PORT_EN]  <= serial_port_enable_q;
					PRDATA[`ASRW_RSC_NINE_BIT_EN]     <= nine_bit_receive_enable_q;
					PRDATA[`ASRW_RSC_SINGLE_RX_EN]    <= single_receive_enable_q;
					PRDATA[`ASRW_RSC_CONT_RX_EN]      <= continuous_receive_enable_q;
					PRDATA[`ASRW_RSC_ADDR_DETECT_EN]  <= address_detect_enable_q;
					PRDATA[`ASRW_RSC_FRAMING_ERR]     <= ~fifo_empty & head[9];
					PRDATA[`ASRW_RSC_OVERRUN_ERR]     <= overrun_error_flag_q;
					PRDATA[`ASRW_RSC_NINTH_BIT]       <= ~fifo_empty & head[8];
				end
				// an empty fifo reads as zero, the dummy after a wake
				`ASRW_ADDR_RX_DATA_PORT: PRDATA[7:0] <= fifo_empty ? 8'h00 : head[7:0];
				`ASRW_ADDR_TX_STATUS_CTRL: begin
					PRDATA[`ASRW_TSC_SYNC_MODE]      <= sync_mode_q;
					PRDATA[`ASRW_TSC_HIGH_SPEED]     <= high_speed_baud_select_q;
					PRDATA[`ASRW_TSC_SHIFTER_EMPTY]  <= 1'b1;
				end
				`ASRW_ADDR_BAUD_CTRL: begin
					PRDATA[`ASRW_BC_RX_IDLE]          <= (state_q == ST_IDLE) |
						(state_q == ST_WAKE);
					PRDATA[`ASRW_BC_RX_POLARITY_INV]  <= receive_polarity_invert_q;
					PRDATA[`ASRW_BC_SIXTEEN_BIT_DIV]  <= sixteen_bit_divisor_select_q;
					PRDATA[`ASRW_BC_WAKEUP_EN]        <= wakeup_enable_q;
				end
				`ASRW_ADDR_BAUD_DIV_HIGH: PRDATA[7:0] <= baud_divisor_high_q;
				`ASRW_ADDR_BAUD_DIV_LOW:  PRDATA[7:0] <= baud_divisor_low_q;
				`ASRW_ADDR_IRQ_CTRL: begin
					PRDATA[`ASRW_IRQ_ENABLE] <= receive_irq_enable_q;
					PRDATA[`ASRW_IRQ_FLAG]   <= receive_irq_flag;
				end
				default: begin
				end
			endcase
		end
	end

endmodule // asrw_top
`default_nettype wire

// File: asrw_assertions.sv
// checker for the bus side and interrupt output of the serial receiver
`timescale 1ns/1ps
`default_nettype none
module asrw_assertions (
	input wire logic        CLK_SYS,          // system clock
	input wire logic        RST,              // synchronous reset
	input wire logic        PSEL,             // apb select
	input wire logic        PENABLE,          // apb access phase
	input wire logic        PWRITE,           // apb direction
	input wire logic [7:0]  PADDR,            // apb address
	input wire logic [31:0] PWDATA,           // apb write data
	input wire logic [31:0] PRDATA,           // apb read data
	input wire logic        PREADY,           // apb ready
	input wire logic        PSLVERR,          // apb error
	input wire logic        SERIAL_INPUT_PIN, // serial line
	input wire logic        SLEEP_MODE,       // sleep request
	input wire logic        RECEIVE_IRQ       // interrupt request
);
	wire logic acc = PSEL && PENABLE;                          // access phase
	wire logic rda = acc && !PWRITE;                           // read access
	wire logic bad = (PADDR > 8'h18) || (PADDR[1:0] != 2'h0); // unmapped
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// error flag follows the map in the access phase
	property p_slverr; acc |-> PSLVERR == bad; endproperty
	a_slverr: assert property (p_slverr) else $error("bus error flag wrong");
	property p_rd_bad; rda && bad |-> PRDATA == 32'h0; endproperty
	a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not zero");
	property p_upper; rda |-> PRDATA[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_tsc; rda && PADDR == 8'h08 |-> PRDATA[1] && (PRDATA[7:0] & 8'hE9) == 8'h0; endproperty
	a_tsc: assert property (p_tsc) else $error("tx status read wrong");
	property p_baud; rda && PADDR == 8'h0C |-> (PRDATA[7:0] & 8'h95) == 8'h0; endproperty
	a_baud: assert property (p_baud) else $error("baud control read wrong");
	// read data stays put once the transfer completes
	property p_hold; acc |=> $stable(PRDATA); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	// request off once the enable is written low
	property p_irq_off; acc && PWRITE && PADDR == 8'h18 && !PWDATA[0] |=> !RECEIVE_IRQ; endproperty
	a_irq_off: assert property (p_irq_off) else $error("request without enable");
	property p_irq_rd; rda && PADDR == 8'h18 && !PRDATA[0] |-> !RECEIVE_IRQ; endproperty
	a_irq_rd: assert property (p_irq_rd) else $error("request while disabled");
	// reset clears data and request on the next edge
	property p_reset; disable iff (1'b0) RST |=> PRDATA == 32'h0 && !RECEIVE_IRQ; endproperty
	a_reset: assert property (p_reset) else $error("reset values wrong");
	c_irq: cover property ($rose(RECEIVE_IRQ));
	c_bad: cover property (acc && bad);
	c_pop: cover property (rda && PADDR == 8'h04);
endmodule // asrw_assertions
bind asrw_top asrw_assertions i_chk (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .PRDATA, .PREADY, .PSLVERR, .SERIAL_INPUT_PIN, .SLEEP_MODE, .RECEIVE_IRQ);
`default_nettype wire

// File: asrw_sender.sv
// model of the remote transmitter on the serial line
`timescale 1ns/1ps
`default_nettype none
module asrw_sender #(
	parameter int BIT = 16              // clocks per bit on the line
) (
	input  wire logic       clk,        // system clock
	input  wire logic       go,         // send one character
	input  wire logic [8:0] data,       // character, ninth bit on top
	input  wire logic       nine,       // nine data bits
	input  wire logic       stop,       // stop level, low forces framing error
	input  wire logic       slow,       // bits four times longer
	input  wire logic       inv,        // line inverted, rests low
	output var  logic       line,       // serial line, idle high, low when inverted
	output var  logic       busy        // frame on the line
);
	logic [11:0] frm;                   // start, data, stop
	int          i;                     // bit index
	initial begin
		line = 1'b1;
		busy = 1'b0;
	end
	// one frame per go; between frames the line rests high, or low when inverted
	always begin
		@(posedge clk);
		if (go) begin
			frm = {2'h3, data, 1'b0};
			frm[nine ? 10 : 9] = stop;
			busy <= 1'b1;
			for (i = 0; i < (nine ? 11 : 10); i++) begin
				line <= frm[i] ^ inv;    // lsb first after start
				repeat (slow ? 4 * BIT : BIT) @(posedge clk);
			end
			line <= ~inv;
			busy <= 1'b0;
		end else begin
			line <= ~inv;            // rest level follows the inversion
		end
	end
endmodule // asrw_sender
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the serial receiver
`timescale 1ns/1ps
`default_nettype none
`include "asrw_consts.vh"
module tb_top;
	logic        clk, rst, psel, penable, pwrite, go, nine, stop, sleep, slow, inv; // drives
	logic [7:0]  paddr;                 // bus address
	logic [31:0] pwdata, r;             // write data, last read
	logic [8:0]  data;                  // character to send
	wire  [31:0] prdata;                // read data
	wire         pready, pslverr, line, irq, busy;
	int          n_errors, check_count, cyc;
	asrw_top i_dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SERIAL_INPUT_PIN(line),
		.SLEEP_MODE(sleep), .RECEIVE_IRQ(irq));
	asrw_sender #(.BIT(16)) i_snd (.clk(clk), .go(go), .data(data), .nine(nine),
		.stop(stop), .slow(slow), .inv(inv), .line(line), .busy(busy));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic conclude;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang guard, far above the few thousand cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			conclude;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; an idle edge follows so psel is never set twice at once
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		for (k = 0; k < 50 && pready !== 1'b1; k++)
			@(posedge clk);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(r, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic irq_is(input logic e);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	// one frame from the far side, then time for the push to land
	task automatic send(input logic [8:0] d, input logic n, input logic s);
		int k;
		go <= 1'b1;
		data <= d;
		nine <= n;
		stop <= s;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		for (k = 0; k < 1000 && busy === 1'b1; k++)
			@(posedge clk);
		repeat (8) @(posedge clk);
	endtask
	task automatic t_reset;
		rd(`ASRW_ADDR_RX_STATUS_CTRL, 32'h00);
		rd(`ASRW_ADDR_TX_STATUS_CTRL, 32'h02);
		rd(`ASRW_ADDR_BAUD_CTRL, 32'h40);
		rd(`ASRW_ADDR_BAUD_DIV_HIGH, 32'h00);
		rd(`ASRW_ADDR_BAUD_DIV_LOW, 32'h00);
		rd(8'h1C, 32'h00);
	endtask
	// fastest divisor: one tick per clock, sixteen clocks a bit
	task automatic t_basic;
		wr(`ASRW_ADDR_TX_STATUS_CTRL, 32'h04);
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'h80);
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'h90);
		wr(`ASRW_ADDR_IRQ_CTRL, 32'h01);
		fork
			send(9'h0A5, 1'b0, 1'b1);
			begin
				repeat (40) @(posedge clk);
				rd(`ASRW_ADDR_BAUD_CTRL, 32'h00);
			end
		join
		irq_is(1'b1);
		rd(`ASRW_ADDR_RX_STATUS_CTRL, 32'h90);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'hA5);
		irq_is(1'b0);
		send(9'h05A, 1'b0, 1'b0);
		rd(`ASRW_ADDR_RX_STATUS_CTRL, 32'h94);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'h5A);
		wr(`ASRW_ADDR_IRQ_CTRL, 32'h00);
		send(9'h03C, 1'b0, 1'b1);
		irq_is(1'b0);
		rd(`ASRW_ADDR_IRQ_CTRL, 32'h02);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'h3C);
		wr(`ASRW_ADDR_IRQ_CTRL, 32'h01);
	endtask
	task automatic t_overrun;
		send(9'h011, 1'b0, 1'b1);
		send(9'h022, 1'b0, 1'b1);
		send(9'h033, 1'b0, 1'b1);
		rd(`ASRW_ADDR_RX_STATUS_CTRL, 32'h92);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'h11);
		irq_is(1'b1);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'h22);
		irq_is(1'b0);
		send(9'h044, 1'b0, 1'b1);
		irq_is(1'b0);
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'h80);
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'h90);
		rd(`ASRW_ADDR_RX_STATUS_CTRL, 32'h90);
		send(9'h055, 1'b0, 1'b1);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'h55);
	endtask
	task automatic t_addr;
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'hD8);
		send(9'h0AA, 1'b1, 1'b1);
		irq_is(1'b0);
		send(9'h1BB, 1'b1, 1'b1);
		rd(`ASRW_ADDR_RX_STATUS_CTRL, 32'hD9);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'hBB);
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'hD0);
		send(9'h0CC, 1'b1, 1'b1);
		irq_is(1'b1);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'hCC);
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'h90);
	endtask
	// slower generator settings, each giving sixty-four clocks a bit
	task automatic t_rate;
		slow <= 1'b1;
		wr(`ASRW_ADDR_TX_STATUS_CTRL, 32'h00);
		send(9'h0C3, 1'b0, 1'b1);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'hC3);
		wr(`ASRW_ADDR_BAUD_CTRL, 32'h08);
		wr(`ASRW_ADDR_BAUD_DIV_LOW, 32'h03);
		send(9'h096, 1'b0, 1'b1);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'h96);
		wr(`ASRW_ADDR_BAUD_CTRL, 32'h00);
		wr(`ASRW_ADDR_TX_STATUS_CTRL, 32'h04);
		wr(`ASRW_ADDR_BAUD_DIV_HIGH, 32'h01);
		rd(`ASRW_ADDR_BAUD_DIV_HIGH, 32'h01);
		send(9'h069, 1'b0, 1'b1);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'h69);
		wr(`ASRW_ADDR_BAUD_DIV_HIGH, 32'h00);
		wr(`ASRW_ADDR_BAUD_DIV_LOW, 32'h00);
		slow <= 1'b0;
	endtask
	// inverted line; receiver off while the rest level flips
	task automatic t_inv;
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'h80);
		inv <= 1'b1;
		wr(`ASRW_ADDR_BAUD_CTRL, 32'h20);
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'h90);
		send(9'h0E1, 1'b0, 1'b1);
		rd(`ASRW_ADDR_RX_STATUS_CTRL, 32'h90);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'hE1);
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'h80);
		inv <= 1'b0;
		wr(`ASRW_ADDR_BAUD_CTRL, 32'h00);
		wr(`ASRW_ADDR_RX_STATUS_CTRL, 32'h90);
	endtask
	// reset in mid-run with a character held
	task automatic t_rst;
		send(9'h077, 1'b0, 1'b1);
		irq_is(1'b1);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`ASRW_ADDR_IRQ_CTRL, 32'h00);
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'h00);
		rd(`ASRW_ADDR_RX_STATUS_CTRL, 32'h00);
	endtask
	// wake on an all-zero character, then sleep with traffic
	task automatic t_wake;
		rd(`ASRW_ADDR_BAUD_CTRL, 32'h40);
		wr(`ASRW_ADDR_BAUD_CTRL, 32'h02);
		rd(`ASRW_ADDR_BAUD_CTRL, 32'h42);
		send(9'h000, 1'b0, 1'b1);
		irq_is(1'b1);
		rd(`ASRW_ADDR_BAUD_CTRL, 32'h40);
		rd(`ASRW_ADDR_RX_STATUS_CTRL, 32'h90);
		apb(`ASRW_ADDR_RX_DATA_PORT, 1'b0, 32'h0);
		irq_is(1'b0);
		sleep <= 1'b1;
		send(9'h03C, 1'b0, 1'b1);
		irq_is(1'b0);
		wr(`ASRW_ADDR_BAUD_CTRL, 32'h02);
		send(9'h000, 1'b0, 1'b1);
		irq_is(1'b1);
		rd(`ASRW_ADDR_BAUD_CTRL, 32'h40);
		sleep <= 1'b0;
		rd(`ASRW_ADDR_RX_DATA_PORT, 32'h00);
		irq_is(1'b0);
	endtask
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		go = 1'b0;
		data = 9'h000;
		nine = 1'b0;
		stop = 1'b1;
		sleep = 1'b0;
		slow = 1'b0;
		inv = 1'b0;
		n_errors = 0;
		check_count = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_basic;
		t_overrun;
		t_addr;
		t_rate;
		t_inv;
		t_wake;
		t_rst;
		conclude;
	end
endmodule // tb_top
`default_nettype wire
